// >>> verilog/cpd_consts.svh
`ifndef CPD_CONSTS_SVH
`define CPD_CONSTS_SVH

// APB byte addresses of the power-control registers.
`define CPD_ADDR_STATUS 12'h000
`define CPD_ADDR_CONTROL 12'h004
`define CPD_ADDR_STATE 12'h008
`define CPD_ADDR_TIMER 12'h00C

// Field positions in the status word.
`define CPD_BIT_IE 0
`define CPD_BIT_EXL 1
`define CPD_BIT_ERL 2
`define CPD_BIT_IM_LO 10
`define CPD_BIT_IM_HI 15
`define CPD_BIT_SR 20
`define CPD_BIT_RP 27

// Field positions in the control word.
`define CPD_BIT_DBG_EXIT 0
`define CPD_BIT_DBG_ENTER 1

// Field positions in the state word.
`define CPD_BIT_ST_SLEEP 0
`define CPD_BIT_ST_DRAIN 1
`define CPD_BIT_ST_DEBUG 2
`define CPD_BIT_ST_WAKE 3
`define CPD_BIT_ST_INT_LO 4
`define CPD_BIT_ST_INT_HI 9
`define CPD_BIT_ST_NMI 10
`define CPD_BIT_ST_DINT 11

// Reset values of the status fields, the debug flag and the timer.
`define CPD_RST_IE 1'b0
`define CPD_RST_EXL 1'b0
`define CPD_RST_ERL 1'b1
`define CPD_RST_IM 6'h00
`define CPD_RST_RP 1'b0
`define CPD_RST_SR 1'b0
`define CPD_RST_DEBUG 1'b0
`define CPD_RST_TIMER 32'h0000_0000

// Timing: bus answers with no wait states; pins pass two flops.
`define CPD_APB_WAIT_CYCLES 0
`define CPD_SYNC_STAGES 2

`endif

// >>> verilog/cpd_pkg.sv
package cpd_pkg;

  typedef enum logic [2:0] {
    CPD_RUN = 3'b001,
    CPD_DRAIN = 3'b010,
    CPD_SLEEP = 3'b100
  } cpd_state_e;

  typedef struct packed {
    logic rp;
    logic sr;
    logic [5:0] im;
    logic error_level_bit;
    logic exception_level_bit;
    logic ie;
  } cpd_status_s;

  typedef struct packed {
    logic [5:0] int_lines;
    logic nmi;
    logic dint;
    logic soft_rst;
    logic cold_rst;
  } cpd_pins_s;

endpackage

// >>> verilog/cpd_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for a group of asynchronous pins.
module cpd_sync
  import cpd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire cpd_pins_s pins_async,
  output cpd_pins_s pins_sync
);

  cpd_pins_s meta_q;
  cpd_pins_s sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins_async;
      sync_q <= meta_q;
    end
  end

  assign pins_sync = sync_q;

endmodule

// >>> verilog/cpd_power_ctl.sv
// How it works
// - reduce_power_out mirrors status bit 27.
// - exception_level_out mirrors status bit 1.
// - error_level_out mirrors status bit 2.
// - debug_mode_out is high while the core is in debug mode.
// - A debug interrupt takes a debug exception and enters debug mode.
// - A taken interrupt sets the exception-level bit, raising its output.
// - Wait at memory stage with idle bus stops clocks and freezes pipeline.
// - Wait with busy bus stalls until idle, then stops clocks.
// - Timer and interrupt, NMI, reset and debug pins keep running in sleep.
// - Enabled interrupt, NMI, debug interrupt or reset wakes the core.
// - sleep_out stays high for the whole sleep and falls on wake.
// - Cold and soft reset set the error-level bit to one.
// - Cold and soft reset clear the reduce-power bit to zero.
`timescale 1ns/10ps
`include "cpd_consts.svh"

module cpd_power_ctl
  import cpd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] int_in,
  input wire logic nmi_in,
  input wire logic debug_interrupt_in,
  input wire logic soft_reset_in,
  input wire logic cold_reset_in,
  input wire logic wait_mstage_in,
  input wire logic bus_idle_in,
  output logic reduce_power_out,
  output logic exception_level_out,
  output logic error_level_out,
  output logic debug_mode_out,
  output logic sleep_out,
  output logic core_clk_en_out,
  output logic pipe_stall_out
);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  function automatic logic [31:0] status_word(input cpd_status_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CPD_BIT_IE] = s.ie;
    w[`CPD_BIT_EXL] = s.exception_level_bit;
    w[`CPD_BIT_ERL] = s.error_level_bit;
    w[`CPD_BIT_IM_HI:`CPD_BIT_IM_LO] = s.im;
    w[`CPD_BIT_SR] = s.sr;
    w[`CPD_BIT_RP] = s.rp;
    status_word = w;
  endfunction

  function automatic cpd_status_s status_from_word(input logic [31:0] w);
    cpd_status_s s;
    s.ie = w[`CPD_BIT_IE];
    s.exception_level_bit = w[`CPD_BIT_EXL];
    s.error_level_bit = w[`CPD_BIT_ERL];
    s.im = w[`CPD_BIT_IM_HI:`CPD_BIT_IM_LO];
    s.sr = w[`CPD_BIT_SR];
    s.rp = w[`CPD_BIT_RP];
    status_from_word = s;
  endfunction

  function automatic logic is_asleep(input cpd_state_e s);
    is_asleep = (s == CPD_SLEEP);
  endfunction

  function automatic logic is_running(input cpd_state_e s);
    is_running = (s == CPD_RUN);
  endfunction

  // Pin synchronisation.
  cpd_pins_s pins_async;
  cpd_pins_s pins;
  cpd_pins_s pins_prev_q;

  assign pins_async.int_lines = int_in;
  assign pins_async.nmi = nmi_in;
  assign pins_async.dint = debug_interrupt_in;
  assign pins_async.soft_rst = soft_reset_in;
  assign pins_async.cold_rst = cold_reset_in;

  cpd_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins_async(pins_async),
    .pins_sync(pins)
  );

  // One cycle of history turns the NMI and debug pins into single-cycle edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev_q <= '0;
    end else begin
      pins_prev_q <= pins;
    end
  end

  // State registers.
  cpd_status_s status_q;
  cpd_status_s status_d;
  cpd_state_e state_q;
  cpd_state_e state_d;
  logic debug_q;
  logic debug_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;

  // Register bus decode.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready_q;
  wire hit_status = (paddr == `CPD_ADDR_STATUS);
  wire hit_control = (paddr == `CPD_ADDR_CONTROL);
  wire hit_state = (paddr == `CPD_ADDR_STATE);
  wire hit_timer = (paddr == `CPD_ADDR_TIMER);
  wire hit_any = hit_status | hit_control | hit_state | hit_timer;
  wire wr_status = access_done & pwrite & hit_status;
  wire wr_control = access_done & pwrite & hit_control;
  wire wr_timer = access_done & pwrite & hit_timer;
  wire dbg_exit_req = wr_control & pwdata[`CPD_BIT_DBG_EXIT];
  wire dbg_enter_req = wr_control & pwdata[`CPD_BIT_DBG_ENTER];

  // Event decode.
  wire reset_hold = pins.soft_rst | pins.cold_rst;
  wire nmi_edge = rise(pins.nmi, pins_prev_q.nmi);
  wire dint_edge = rise(pins.dint, pins_prev_q.dint);
  wire int_enabled = (|(pins.int_lines & status_q.im)) & status_q.ie;
  wire int_take = int_enabled & ~status_q.exception_level_bit & ~status_q.error_level_bit & ~debug_q;
  // Wake on an interrupt looks only at IE and IM, not at EXCEPTION_LEVEL_BIT or ERROR_LEVEL_BIT.
  wire wake_by_int = int_enabled;
  wire wake_by_nmi = nmi_edge;
  wire wake_by_dint = dint_edge;
  wire wake_event = wake_by_int | wake_by_nmi | wake_by_dint | reset_hold;
  wire stop_clocks = is_asleep(state_d);
  wire pipe_hold = ~is_running(state_d);

  logic [31:0] state_word;

  always_comb begin
    state_word = 32'h0000_0000;
    state_word[`CPD_BIT_ST_SLEEP] = is_asleep(state_q);
    state_word[`CPD_BIT_ST_DRAIN] = (state_q == CPD_DRAIN);
    state_word[`CPD_BIT_ST_DEBUG] = debug_q;
    state_word[`CPD_BIT_ST_WAKE] = int_enabled;
    state_word[`CPD_BIT_ST_INT_HI:`CPD_BIT_ST_INT_LO] = pins.int_lines;
    state_word[`CPD_BIT_ST_NMI] = pins.nmi;
    state_word[`CPD_BIT_ST_DINT] = pins.dint;
  end

  assign rdata_d = hit_status ? status_word(status_q) :
                   hit_control ? {31'h0000_0000, debug_q} :
                   hit_state ? state_word :
                   hit_timer ? timer_q : 32'h0000_0000;

  // Status register next value; hardware sets win over a software write.
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_from_word(pwdata);
      status_d.sr = status_q.sr;
    end
    if (int_take) begin
      status_d.exception_level_bit = 1'b1;
    end
    if (nmi_edge) begin
      status_d.error_level_bit = 1'b1;
    end
    // A held reset pin overrides every other update in the same cycle.
    if (reset_hold) begin
      status_d.ie = `CPD_RST_IE;
      status_d.exception_level_bit = `CPD_RST_EXL;
      status_d.im = `CPD_RST_IM;
      status_d.error_level_bit = `CPD_RST_ERL;
      status_d.rp = `CPD_RST_RP;
      status_d.sr = pins.soft_rst & ~pins.cold_rst;
    end
  end

  // Debug mode: entered on a debug exception, left by a control write.
  always_comb begin
    debug_d = debug_q;
    if (dbg_exit_req) begin
      debug_d = 1'b0;
    end
    if (dint_edge | dbg_enter_req) begin
      debug_d = 1'b1;
    end
    if (reset_hold) begin
      debug_d = `CPD_RST_DEBUG;
    end
  end

  // timer runs in sleep
  // The timer has no link to the sequencer, so it keeps counting while the core sleeps.
  assign timer_d = wr_timer ? pwdata : timer_q + 32'h0000_0001;

  // Sleep sequencer.
  // A wait seen in drain or sleep is ignored; only a reset leaves drain early.
  always_comb begin
    state_d = state_q;
    case (state_q)
      CPD_RUN: begin
        if (wait_mstage_in & ~reset_hold) begin
          state_d = bus_idle_in ? CPD_SLEEP : CPD_DRAIN;
        end
      end
      CPD_DRAIN: begin
        if (reset_hold) begin
          state_d = CPD_RUN;
        end else if (bus_idle_in) begin
          state_d = CPD_SLEEP;
        end
      end
      CPD_SLEEP: begin
        if (wake_event) begin
          state_d = CPD_RUN;
        end
      end
      default: begin
        state_d = CPD_RUN;
      end
    endcase
  end

  // Status, debug flag, timer and sequencer share one reset branch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q.ie <= `CPD_RST_IE;
      status_q.exception_level_bit <= `CPD_RST_EXL;
      status_q.error_level_bit <= `CPD_RST_ERL;
      status_q.im <= `CPD_RST_IM;
      status_q.sr <= `CPD_RST_SR;
      status_q.rp <= `CPD_RST_RP;
      debug_q <= `CPD_RST_DEBUG;
      timer_q <= `CPD_RST_TIMER;
      state_q <= CPD_RUN;
    end else begin
      status_q <= status_d;
      debug_q <= debug_d;
      timer_q <= timer_d;
      state_q <= state_d;
    end
  end

  // Ready is low only until the first edge after reset; the slave never inserts waits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
    end
  end

  // Bus answer: data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (setup_phase) begin
        pslverr_q <= ~hit_any;
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      end
    end
  end

  // Output flops.
  logic rp_out_q;
  logic exl_out_q;
  logic erl_out_q;
  logic sleep_q;
  logic clk_en_q;
  logic stall_q;

  // Mirrors copy the status flops, so they cannot glitch while the status word settles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_out_q <= `CPD_RST_RP;
      exl_out_q <= `CPD_RST_EXL;
      erl_out_q <= `CPD_RST_ERL;
    end else begin
      rp_out_q <= status_q.rp;
      exl_out_q <= status_q.exception_level_bit;
      erl_out_q <= status_q.error_level_bit;
    end
  end

  // Sleep outputs load from the next state, so they move on the edge the sequencer does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
      clk_en_q <= 1'b1;
      stall_q <= 1'b0;
    end else begin
      sleep_q <= stop_clocks;
      clk_en_q <= ~stop_clocks;
      stall_q <= pipe_hold;
    end
  end

  assign reduce_power_out = rp_out_q;
  assign exception_level_out = exl_out_q;
  assign error_level_out = erl_out_q;
  assign debug_mode_out = debug_q;
  assign sleep_out = sleep_q;
  assign core_clk_en_out = clk_en_q;
  assign pipe_stall_out = stall_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule

// >>> verif/cpd_agent_model.sv
`timescale 1ns/10ps
module cpd_agent_model
  import cpd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reduce_power_out,
  input wire logic error_level_out,
  input wire logic debug_mode_out,
  output logic fast_clk_q
);
  logic fast_clk_d;
  assign fast_clk_d = error_level_out || debug_mode_out || !reduce_power_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_clk_q <= 1'b1;
    end else begin
      fast_clk_q <= fast_clk_d;
    end
  end
endmodule

// >>> verif/cpd_power_ctl_chk.sv
`timescale 1ns/10ps
module cpd_power_ctl_chk
  import cpd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic nmi_in,
  input wire logic debug_interrupt_in,
  input wire logic soft_reset_in,
  input wire logic wait_mstage_in,
  input wire logic bus_idle_in,
  input wire logic reduce_power_out,
  input wire logic exception_level_out,
  input wire logic error_level_out,
  input wire logic debug_mode_out,
  input wire logic sleep_out,
  input wire logic core_clk_en_out,
  input wire logic pipe_stall_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    wait_mstage_in && !pipe_stall_out;
  endsequence
  sequence s_wr;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  AST_ENTER: assert property (s_wait ##0 bus_idle_in |=> sleep_out && !core_clk_en_out)
    else $error("no sleep");
  AST_DRAIN: assert property (s_wait ##0 !bus_idle_in |=> pipe_stall_out && !sleep_out)
    else $error("no drain");
  AST_DRAIN_END: assert property (pipe_stall_out && !sleep_out
    |=> sleep_out == $past(bus_idle_in)) else $error("drain exit");
  AST_SLEEP_HOLD: assert property (sleep_out |-> !core_clk_en_out && pipe_stall_out)
    else $error("sleep outputs");
  AST_NMI_WAKE: assert property (sleep_out && $rose(nmi_in) |-> ##[1:4] !sleep_out)
    else $error("nmi wake");
  AST_DEBUG: assert property ($rose(debug_interrupt_in) |-> ##[1:5] debug_mode_out)
    else $error("debug entry");
  AST_SOFT_RST: assert property ($rose(soft_reset_in)
    |-> ##[2:6] error_level_out && !reduce_power_out) else $error("soft reset");
  AST_MIRROR: assert property (s_wr |-> ##2 {reduce_power_out, error_level_out,
    exception_level_out} == $past({pwdata[27], pwdata[2], pwdata[1]}, 2))
    else $error("mirror");
endmodule
bind cpd_power_ctl cpd_power_ctl_chk chk_u (.*);

// >>> verif/cpd_power_ctl_test.sv
`timescale 1ns/10ps
module cpd_power_ctl_test
  import cpd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, nmi_in, dint_in, soft_in, cold_in;
  logic wait_in, idle_in, pready, pslverr, err, rp_o, exl_o, erl_o, dbg_o, slp_o;
  logic clken_o, stall_o, fast_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t1;
  logic [5:0] int_in;
  int failures, total_checks;
  cpd_power_ctl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_in(int_in), .nmi_in(nmi_in), .debug_interrupt_in(dint_in),
    .soft_reset_in(soft_in), .cold_reset_in(cold_in), .wait_mstage_in(wait_in),
    .bus_idle_in(idle_in), .reduce_power_out(rp_o), .exception_level_out(exl_o),
    .error_level_out(erl_o), .debug_mode_out(dbg_o), .sleep_out(slp_o),
    .core_clk_en_out(clken_o), .pipe_stall_out(stall_o));
  cpd_agent_model agent_u (.pclk(pclk), .presetn(presetn), .reduce_power_out(rp_o),
    .error_level_out(erl_o), .debug_mode_out(dbg_o), .fast_clk_q(fast_q));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task lim(input int n);
    if (n >= 20) begin
      failures++;
      wrap_up;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    lim(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_slp(input logic v);
    int n;
    n = 0;
    while (slp_o !== v && n < 20) begin
      @(posedge pclk);
      n++;
    end
    lim(n);
  endtask
  task go_wait;
    wait_in <= 1'b1;
    @(posedge pclk);
    wait_in <= 1'b0;
    cyc(3);
  endtask
  task t_reset;
    chk("erl_rp", 32'h2, {erl_o, rp_o});
    apb(1'b0, 12'h000, 32'h0);
    chk("status", 32'h4, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, err);
  endtask
  task t_mirror;
    apb(1'b1, 12'h000, 32'h0800_0002);
    cyc(2);
    chk("mirror_on", 32'h5, {rp_o, erl_o, exl_o});
    chk("agent", 32'h0, fast_q);
    apb(1'b1, 12'h000, 32'h0800_0004);
    cyc(2);
    chk("agent_err", 32'h1, fast_q);
    apb(1'b1, 12'h000, 32'h0);
    cyc(1);
    chk("mirror_off", 32'h0, {rp_o, erl_o, exl_o});
  endtask
  task t_sleep_int;
    apb(1'b1, 12'h000, 32'h0000_0401);
    go_wait;
    chk("sleep", 32'h2, {slp_o, clken_o});
    apb(1'b0, 12'h00C, 32'h0);
    t1 = rd;
    apb(1'b0, 12'h00C, 32'h0);
    chk("timer", 32'h3, rd - t1);
    apb(1'b1, 12'h00C, 32'h0000_0100);
    apb(1'b0, 12'h00C, 32'h0);
    chk("timer_wr", 32'h0000_0101, rd);
    int_in <= 6'h01;
    wait_slp(1'b0);
    cyc(3);
    chk("wake_exl", 32'h3, {clken_o, exl_o});
    int_in <= 6'h00;
    cyc(3);
    apb(1'b1, 12'h000, 32'h0);
  endtask
  task t_drain_nmi;
    idle_in <= 1'b0;
    go_wait;
    chk("drain", 32'h1, {slp_o, stall_o});
    idle_in <= 1'b1;
    cyc(3);
    chk("drain_end", 32'h3, {slp_o, stall_o});
    nmi_in <= 1'b1;
    wait_slp(1'b0);
    nmi_in <= 1'b0;
    cyc(3);
    chk("nmi_erl", 32'h1, erl_o);
  endtask
  task t_debug;
    go_wait;
    dint_in <= 1'b1;
    wait_slp(1'b0);
    cyc(2);
    chk("debug_on", 32'h1, dbg_o);
    dint_in <= 1'b0;
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("debug_rd", 32'h0, rd);
    chk("debug_off", 32'h0, dbg_o);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk("state_dbg", 32'h0000_0004, rd);
    chk("debug_sw", 32'h1, dbg_o);
    apb(1'b1, 12'h004, 32'h1);
  endtask
  task t_pin_rst(input logic cold);
    apb(1'b1, 12'h000, 32'h0800_0000);
    if (cold) begin
      cold_in <= 1'b1;
    end else begin
      soft_in <= 1'b1;
    end
    cyc(3);
    {soft_in, cold_in} <= 2'h0;
    cyc(4);
    chk("pin_rst", 32'h2, {erl_o, rp_o});
    apb(1'b0, 12'h000, 32'h0);
    chk("pin_sr", cold ? 32'h4 : 32'h0010_0004, rd);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, nmi_in, dint_in, soft_in, cold_in, wait_in} = '0;
    {paddr, pwdata, int_in} = '0;
    idle_in = 1'b1;
    failures = 0;
    total_checks = 0;
    cyc(3);
    presetn <= 1'b1;
    cyc(2);
    t_reset;
    t_mirror;
    t_sleep_int;
    t_drain_nmi;
    t_debug;
    t_pin_rst(1'b0);
    t_pin_rst(1'b1);
    wrap_up;
  end
endmodule
